// file: pkg/ibo_pkg.sv
/*
 * Shared constants and types for the increment, OR, move and branch execution block.
 * Assumes a single core clock and that every user of these names imports the whole package.
 */
`default_nettype none

package ibo_pkg;

	// ------------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------------
	localparam int unsigned IBO_DATA_W  = 8;
	localparam int unsigned IBO_FADDR_W = 7;
	localparam int unsigned IBO_LIT_W   = 11;
	localparam int unsigned IBO_PC_W    = 13;
	localparam int unsigned IBO_LATCH_W = 8;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int unsigned IBO_LATCH_HI = 4;
	localparam int unsigned IBO_LATCH_LO = 3;
	localparam int unsigned IBO_LIT8_HI  = 7;

	// ------------------------------------------------------------------
	// Direction operand encoding, reset values and increment and counter step constants
	// ------------------------------------------------------------------
	localparam logic IBO_DEST_ACCUM = 1'h0;
	localparam logic IBO_DEST_FILE  = 1'h1;

	localparam logic [IBO_DATA_W-1:0]  IBO_ZERO_DATA = 8'h00;
	localparam logic [IBO_DATA_W-1:0]  IBO_ONE_DATA  = 8'h01;
	localparam logic [IBO_FADDR_W-1:0] IBO_ZERO_ADDR = 7'h00;
	localparam logic [IBO_PC_W-1:0]    IBO_PC_RESET  = 13'h0000;
	localparam logic [IBO_PC_W-1:0]    IBO_PC_STEP   = 13'h0001;
	localparam logic [IBO_PC_W-1:0]    IBO_PC_SKIP   = 13'h0002;

	// ------------------------------------------------------------------
	// Decoded operation codes
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		IBO_OP_NONE     = 3'h0,
		IBO_OP_INC_SKIP = 3'h1,
		IBO_OP_INC      = 3'h2,
		IBO_OP_BRANCH   = 3'h3,
		IBO_OP_OR_LIT   = 3'h4,
		IBO_OP_OR_FILE  = 3'h5,
		IBO_OP_MOVE     = 3'h6
	} ibo_op_t;

	// Execution states, one-hot.
	typedef enum logic [1:0] {
		IBO_ST_EXEC  = 2'h1,
		IBO_ST_FLUSH = 2'h2
	} ibo_state_t;

endpackage

`default_nettype wire

// file: rtl/ibo_alu.sv
/*
 * Result datapath: increment, OR with literal or file operand, and plain move.
 * Assumes operands are stable within the cycle; purely combinational.
 */
`timescale 1ns/10ps
`default_nettype none

module ibo_alu
	import ibo_pkg::*;
(
	input  wire ibo_op_t               op,          // Decoded operation
	input  wire logic [IBO_DATA_W-1:0] accum,       // Working register value
	input  wire logic [IBO_DATA_W-1:0] file_val,    // Addressed file register value
	input  wire logic [IBO_DATA_W-1:0] literal8,    // Eight-bit immediate
	output logic      [IBO_DATA_W-1:0] result,      // Operation result
	output logic                       result_zero, // Result is all zero
	output logic                       zero_update  // Operation affects the zero flag
);

	// ------------------------------------------------------------------
	// Datapath
	// ------------------------------------------------------------------
	always_comb begin
		result      = file_val;
		zero_update = 1'b0;
		case (op)
			IBO_OP_INC_SKIP: begin
				// Eight-bit add drops the carry, so all ones wraps to zero.
				result = IBO_DATA_W'(file_val + IBO_ONE_DATA);
			end
			IBO_OP_INC: begin
				result      = IBO_DATA_W'(file_val + IBO_ONE_DATA);
				zero_update = 1'b1;
			end
			IBO_OP_OR_LIT: begin
				result      = accum | literal8;
				zero_update = 1'b1;
			end
			IBO_OP_OR_FILE: begin
				result      = accum | file_val;
				zero_update = 1'b1;
			end
			IBO_OP_MOVE: begin
				result      = file_val;
				zero_update = 1'b1;
			end
			default: begin
				result      = file_val;
				zero_update = 1'b0;
			end
		endcase
	end

	assign result_zero = (result == IBO_ZERO_DATA);

endmodule

`default_nettype wire

// file: rtl/ibo_core.sv
/*
 * Execution block for a subset of an 8-bit core's instruction set: increment with
 * skip on zero, increment, unconditional branch, OR with literal or file register,
 * and move from file register. Holds the working register, the zero flag and the
 * program counter.
 * Assumes instructions arrive already decoded from logic on the same clock, that the
 * file register array is core-internal with a combinational read port, and that the
 * fetch side drops the prefetched word whenever a flush cycle is shown.
 */


`timescale 1ns/10ps
`default_nettype none

module ibo_core
	import ibo_pkg::*;
#(
	parameter logic [IBO_PC_W-1:0] PC_RESET = IBO_PC_RESET // Counter value after reset
)
(
	input  wire logic                    mclk,                // Core clock, 200 MHz
	input  wire logic                    sys_rst,             // Asynchronous reset, active high
	input  wire logic                    op_valid,            // Decoded instruction present
	output logic                         op_ready,            // Ready to take an instruction this cycle
	input  wire ibo_op_t                 op_code,             // Decoded operation
	input  wire logic [IBO_FADDR_W-1:0]  op_file_addr,        // File register operand
	input  wire logic                    op_dest,             // Direction operand
	input  wire logic [IBO_LIT_W-1:0]    op_literal,          // Immediate, 11 bits for branch
	input  wire logic [IBO_LATCH_W-1:0]  upper_address_latch, // Upper program address latch
	output logic      [IBO_FADDR_W-1:0]  file_rd_addr,        // File read address
	input  wire logic [IBO_DATA_W-1:0]   file_rd_data,        // File read data, same cycle
	output logic                         file_wr_en,          // File write strobe
	output logic      [IBO_FADDR_W-1:0]  file_wr_addr,        // File write address
	output logic      [IBO_DATA_W-1:0]   file_wr_data,        // File write data
	output logic      [IBO_DATA_W-1:0]   accum,               // Working register
	output logic                         zero_flag,           // Zero status flag
	output logic      [IBO_PC_W-1:0]     pc,                  // Program counter
	output logic                         flush_cycle          // Second cycle executes as no-op
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	ibo_state_t                state_q;
	ibo_state_t                state_d;
	logic [IBO_DATA_W-1:0]     accum_q;
	logic [IBO_DATA_W-1:0]     accum_d;
	logic                      zero_q;
	logic                      zero_d;
	logic [IBO_PC_W-1:0]       pc_q;
	logic [IBO_PC_W-1:0]       pc_d;
	logic                      wr_en_q;
	logic                      wr_en_d;
	logic [IBO_FADDR_W-1:0]    wr_addr_q;
	logic [IBO_FADDR_W-1:0]    wr_addr_d;
	logic [IBO_DATA_W-1:0]     wr_data_q;
	logic [IBO_DATA_W-1:0]     wr_data_d;

	// ------------------------------------------------------------------
	// Datapath
	// ------------------------------------------------------------------
	logic [IBO_DATA_W-1:0]     alu_result;
	logic                      alu_zero;
	logic                      alu_zero_update;
	logic                      take;
	logic                      routes_by_dest;
	logic [IBO_PC_W-1:0]       branch_target;
	logic                      skip_hit;

	ibo_alu u_alu (
		.op          (op_code),
		.accum       (accum_q),
		.file_val    (file_rd_data),
		.literal8    (op_literal[IBO_LIT8_HI:0]),
		.result      (alu_result),
		.result_zero (alu_zero),
		.zero_update (alu_zero_update)
	);

	// Only the exec state accepts work; the flush cycle refuses it so the
	// fetch side sees the stall as the lost slot.
	assign op_ready     = (state_q == IBO_ST_EXEC);
	assign take         = op_valid && op_ready;
	assign file_rd_addr = op_file_addr;
	assign flush_cycle  = (state_q == IBO_ST_FLUSH);

	// ------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------
	// Only the file-operand instructions obey the direction operand; a literal OR and a
	// branch ignore it even when it is high.
	assign routes_by_dest = (op_code == IBO_OP_INC_SKIP) || (op_code == IBO_OP_INC)
		|| (op_code == IBO_OP_OR_FILE) || (op_code == IBO_OP_MOVE);
	assign skip_hit       = (op_code == IBO_OP_INC_SKIP) && alu_zero;

	assign branch_target = {upper_address_latch[IBO_LATCH_HI:IBO_LATCH_LO], op_literal};

	// ------------------------------------------------------------------
	// Sequencing: program counter and flush slot
	// ------------------------------------------------------------------
	// The counter steps by two on a skip so that the fetch side only has to drop the
	// one prefetched word; the flush slot is that dropped word.
	always_comb begin
		state_d = state_q;
		pc_d    = pc_q;
		case (state_q)
			IBO_ST_EXEC: begin
				if (take) begin
					pc_d = IBO_PC_W'(pc_q + IBO_PC_STEP);
					if (skip_hit) begin
						// The skipped word still advances the counter.
						pc_d    = IBO_PC_W'(pc_q + IBO_PC_SKIP);
						state_d = IBO_ST_FLUSH;
					end
					if (op_code == IBO_OP_BRANCH) begin
						pc_d    = branch_target;
						state_d = IBO_ST_FLUSH;
					end
				end
			end
			IBO_ST_FLUSH: begin
				// Flags and registers hold; this is the no-op cycle.
				state_d = IBO_ST_EXEC;
			end
			default: begin
				state_d = IBO_ST_EXEC;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= IBO_ST_EXEC;
			pc_q    <= PC_RESET;
		end else begin
			state_q <= state_d;
			pc_q    <= pc_d;
		end
	end

	// ------------------------------------------------------------------
	// Working register and zero flag
	// ------------------------------------------------------------------
	// A take only happens in the exec state, so the flush slot leaves both untouched.
	always_comb begin
		accum_d = accum_q;
		zero_d  = zero_q;
		if (take) begin
			if (routes_by_dest && (op_dest == IBO_DEST_ACCUM)) begin
				accum_d = alu_result;
			end
			if (op_code == IBO_OP_OR_LIT) begin
				accum_d = alu_result;
			end
			// Increment-and-skip and branch never reach this update.
			if (alu_zero_update) begin
				zero_d = alu_zero;
			end
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			accum_q <= IBO_ZERO_DATA;
			zero_q  <= 1'b0;
		end else begin
			accum_q <= accum_d;
			zero_q  <= zero_d;
		end
	end

	// ------------------------------------------------------------------
	// File write port
	// ------------------------------------------------------------------
	always_comb begin
		wr_en_d   = 1'b0;
		wr_addr_d = wr_addr_q;
		wr_data_d = wr_data_q;
		if (take && routes_by_dest && (op_dest == IBO_DEST_FILE)) begin
			// A write back onto the same value still strobes, so a move onto itself is seen.
			wr_en_d   = 1'b1;
			wr_addr_d = op_file_addr;
			wr_data_d = alu_result;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_en_q   <= 1'b0;
			wr_addr_q <= IBO_ZERO_ADDR;
			wr_data_q <= IBO_ZERO_DATA;
		end else begin
			wr_en_q   <= wr_en_d;
			wr_addr_q <= wr_addr_d;
			wr_data_q <= wr_data_d;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	// File writes land one cycle after the take, so an instruction that reads the same
	// address in the very next cycle sees the old value unless the register file
	// forwards it; this block leaves forwarding to the register file.
	assign accum        = accum_q;
	assign zero_flag    = zero_q;
	assign pc           = pc_q;
	assign file_wr_en   = wr_en_q;
	assign file_wr_addr = wr_addr_q;
	assign file_wr_data = wr_data_q;

endmodule

`default_nettype wire

// file: verification/ibo_core_monitor.sv
/*
 * Port checker for the execution block.
 * Assumes it is bound onto ibo_core, with reset asynchronous and active high.
 */
`timescale 1ns/10ps
`default_nettype none
module ibo_core_monitor
	import ibo_pkg::*;
(
	input wire logic                   mclk,                // Clock
	input wire logic                   sys_rst,             // Reset
	input wire logic                   op_valid,            // Request
	input wire logic                   op_ready,            // Accepting
	input wire ibo_op_t                op_code,             // Operation
	input wire logic [IBO_FADDR_W-1:0] op_file_addr,        // File operand
	input wire logic                   op_dest,             // Direction
	input wire logic [IBO_LIT_W-1:0]   op_literal,          // Immediate
	input wire logic [IBO_LATCH_W-1:0] upper_address_latch, // Upper latch
	input wire logic [IBO_DATA_W-1:0]  file_rd_data,        // File data
	input wire logic                   file_wr_en,          // Write strobe
	input wire logic [IBO_FADDR_W-1:0] file_wr_addr,        // Write address
	input wire logic [IBO_DATA_W-1:0]  file_wr_data,        // Write data
	input wire logic [IBO_DATA_W-1:0]  accum,               // Working register
	input wire logic                   zero_flag,           // Zero flag
	input wire logic [IBO_PC_W-1:0]    pc,                  // Counter
	input wire logic                   flush_cycle          // No-op cycle
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Slices are taken here so that every $past sees a whole signal.
	logic       tk;
	logic       fop;
	logic [1:0] upb;
	logic [7:0] lit8;
	assign tk = op_valid && op_ready;
	assign fop = op_code inside {IBO_OP_INC, IBO_OP_INC_SKIP, IBO_OP_OR_FILE, IBO_OP_MOVE};
	assign upb = upper_address_latch[IBO_LATCH_HI:IBO_LATCH_LO];
	assign lit8 = op_literal[IBO_LIT8_HI:0];
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	branch_target_a: assert property (tk && op_code == IBO_OP_BRANCH |=>
		pc == {$past(upb), $past(op_literal)}) else $error("branch target wrong");
	branch_flush_a: assert property (tk && op_code == IBO_OP_BRANCH |=>
		flush_cycle && !op_ready && $stable(zero_flag) ##1 op_ready) else $error("branch flush");
	skip_zero_a: assert property (tk && op_code == IBO_OP_INC_SKIP && file_rd_data == 8'hFF
		|=> flush_cycle && pc == $past(pc) + IBO_PC_SKIP) else $error("skip not taken");
	skip_flag_a: assert property (tk && op_code == IBO_OP_INC_SKIP |=>
		$stable(zero_flag)) else $error("skip changed flag");
	or_literal_a: assert property (tk && op_code == IBO_OP_OR_LIT |=>
		accum == ($past(accum) | $past(lit8)) && zero_flag == (accum == 8'h00))
		else $error("literal OR wrong");
	or_file_a: assert property (tk && op_code == IBO_OP_OR_FILE |=>
		zero_flag == (($past(accum) | $past(file_rd_data)) == 8'h00)) else $error("file OR flag");
	dest_file_a: assert property (tk && fop && op_dest |=>
		file_wr_en && file_wr_addr == $past(op_file_addr)) else $error("file write missing");
	dest_accum_a: assert property (tk && fop && !op_dest |=> !file_wr_en)
		else $error("stray file write");
	inc_wrap_a: assert property (tk && op_code == IBO_OP_INC && op_dest |=>
		file_wr_data == $past(file_rd_data) + 8'h01 && zero_flag == (file_wr_data == 8'h00))
		else $error("increment wrong");
	move_flag_a: assert property (tk && op_code == IBO_OP_MOVE |=>
		zero_flag == ($past(file_rd_data) == 8'h00)) else $error("move flag wrong");

	cover property (tk && op_code == IBO_OP_BRANCH);
	cover property (flush_cycle && tk == 1'b0);
	cover property (file_wr_en && file_wr_data == 8'h00);
endmodule
`default_nettype wire

// file: verification/ibo_core_test.sv
/*
 * Directed testbench for the execution block.
 * Assumes the file register array is played by the bench on file_rd_data.
 */
`timescale 1ns/10ps
`default_nettype none
module ibo_core_test
	import ibo_pkg::*;
;
	logic                   mclk, sys_rst, op_valid, op_dest, op_ready;
	logic                   file_wr_en, zero_flag, flush_cycle;
	ibo_op_t                op_code;
	logic [IBO_FADDR_W-1:0] op_file_addr, file_rd_addr, file_wr_addr;
	logic [IBO_LIT_W-1:0]   op_literal;
	logic [IBO_LATCH_W-1:0] upper_address_latch;
	logic [IBO_DATA_W-1:0]  file_rd_data, file_wr_data, accum;
	logic [IBO_PC_W-1:0]    pc, pc0;
	int                     failures = 0;
	int                     n_tests = 0;

	ibo_core dut_u (.mclk, .sys_rst, .op_valid, .op_ready, .op_code, .op_file_addr,
		.op_dest, .op_literal, .upper_address_latch, .file_rd_addr, .file_rd_data,
		.file_wr_en, .file_wr_addr, .file_wr_data, .accum, .zero_flag, .pc, .flush_cycle);

	initial mclk = 1'b0;
	always #2.5 mclk = ~mclk;

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %0t %s: %h vs %h", $time, m, seen, exp);
		end
	endtask

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Holds the request until taken; returns at the negedge after the take edge.
	task automatic run(ibo_op_t c, logic [6:0] a, logic d, logic [10:0] k, logic [7:0] rd);
		int n;
		n = 0;
		@(posedge mclk);
		op_valid <= 1'b1;
		op_code <= c;
		op_file_addr <= a;
		op_dest <= d;
		op_literal <= k;
		file_rd_data <= rd;
		@(negedge mclk);
		while (op_ready !== 1'b1 && n < 8) begin
			n++;
			@(negedge mclk);
		end
		pc0 = pc;
		@(posedge mclk);
		op_valid <= 1'b0;
		@(negedge mclk);
	endtask

	task automatic t_inc;
		run(IBO_OP_INC, 7'h05, 1'b1, 11'h000, 8'hFF);
		chk(file_wr_en, 1'b1, "inc write");
		chk(file_wr_addr, 7'h05, "inc addr");
		chk(file_rd_addr, 7'h05, "read addr");
		chk(file_wr_data, 8'h00, "inc wrap");
		chk(zero_flag, 1'b1, "inc zero");
		chk(pc, pc0 + 13'h0001, "inc pc");
		run(IBO_OP_INC, 7'h09, 1'b0, 11'h000, 8'h41);
		chk({file_wr_en, accum, zero_flag}, {1'b0, 8'h42, 1'b0}, "inc to accum");
		$display("inc done");
	endtask

	task automatic t_move;
		run(IBO_OP_MOVE, 7'h11, 1'b0, 11'h000, 8'h80);
		chk({file_wr_en, accum, zero_flag}, {1'b0, 8'h80, 1'b0}, "move to accum");
		run(IBO_OP_MOVE, 7'h11, 1'b1, 11'h000, 8'h00);
		chk({file_wr_en, file_wr_data, zero_flag}, {1'b1, 8'h00, 1'b1}, "move self");
		$display("move done");
	endtask

	task automatic t_skip;
		run(IBO_OP_INC_SKIP, 7'h03, 1'b0, 11'h000, 8'hFF);
		chk({accum, zero_flag}, {8'h00, 1'b1}, "skip result");
		chk({flush_cycle, op_ready}, 2'b10, "skip flush");
		chk(pc, pc0 + 13'h0002, "skip pc");
		run(IBO_OP_INC_SKIP, 7'h03, 1'b1, 11'h000, 8'h10);
		chk({flush_cycle, file_wr_data, zero_flag}, {1'b0, 8'h11, 1'b1}, "no skip");
		chk(pc, pc0 + 13'h0001, "no skip pc");
		$display("skip done");
	endtask

	task automatic t_branch;
		@(posedge mclk);
		upper_address_latch <= 8'h08;
		run(IBO_OP_BRANCH, 7'h00, 1'b0, 11'h7FF, 8'h00);
		chk(pc, 13'h0FFF, "branch low");
		chk({flush_cycle, op_ready, zero_flag}, 3'b101, "branch flush");
		@(posedge mclk);
		upper_address_latch <= 8'hF7;
		run(IBO_OP_BRANCH, 7'h00, 1'b0, 11'h001, 8'h00);
		chk(pc, 13'h1001, "branch high");
		$display("branch done");
	endtask

	task automatic t_or;
		run(IBO_OP_OR_LIT, 7'h00, 1'b1, 11'h700, 8'h00);
		chk({file_wr_en, accum, zero_flag}, {1'b0, 8'h00, 1'b1}, "or zero");
		run(IBO_OP_OR_LIT, 7'h00, 1'b0, 11'h0A5, 8'h00);
		chk({accum, zero_flag}, {8'hA5, 1'b0}, "or literal");
		run(IBO_OP_OR_FILE, 7'h22, 1'b1, 11'h000, 8'h5A);
		chk({file_wr_en, file_wr_data, accum}, {1'b1, 8'hFF, 8'hA5}, "or to file");
		run(IBO_OP_OR_FILE, 7'h22, 1'b0, 11'h000, 8'h00);
		chk({file_wr_en, accum, zero_flag}, {1'b0, 8'hA5, 1'b0}, "or to accum");
		$display("or done");
	endtask

	// Reset in mid-run, then a literal OR of zero must raise the cleared flag.
	task automatic t_reset;
		@(posedge mclk);
		sys_rst <= 1'b1;
		@(negedge mclk);
		chk({accum, zero_flag, pc, flush_cycle, op_ready}, {8'h00, 1'b0, 13'h0000, 2'b01}, "mid reset");
		@(posedge mclk);
		sys_rst <= 1'b0;
		run(IBO_OP_OR_LIT, 7'h00, 1'b0, 11'h700, 8'h00);
		chk({accum, zero_flag, pc}, {8'h00, 1'b1, 13'h0001}, "or sets zero");
		$display("reset done");
	endtask

	initial begin
		sys_rst = 1'b1;
		op_valid = 1'b0;
		op_code = IBO_OP_NONE;
		op_file_addr = 7'h00;
		op_dest = 1'b0;
		op_literal = 11'h000;
		upper_address_latch = 8'h00;
		file_rd_data = 8'h00;
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		@(negedge mclk);
		chk({accum, zero_flag, pc, flush_cycle, op_ready, file_wr_en}, 25'h0000002, "reset values");
		t_inc();
		t_move();
		t_skip();
		t_branch();
		t_or();
		t_reset();
		finish_test();
	end

	initial begin
		#5000;
		failures++;
		finish_test();
	end
endmodule
bind ibo_core ibo_core_monitor mon_u (.mclk, .sys_rst, .op_valid, .op_ready, .op_code,
	.op_file_addr, .op_dest, .op_literal, .upper_address_latch, .file_rd_data, .file_wr_en,
	.file_wr_addr, .file_wr_data, .accum, .zero_flag, .pc, .flush_cycle);
`default_nettype wire
